// ### logic/usstw_params.svh
// usstw_params.svh: widths, reset values and codes of the shift unit
// assumes: included by the package and by the design file
`ifndef USSTW_PARAMS_SVH
`define USSTW_PARAMS_SVH

// data and counter widths
`define USSTW_DATA_W 8
`define USSTW_CNT_W 4
`define USSTW_MSB 7

// wire mode codes
`define USSTW_WM_OFF 2'h0
`define USSTW_WM_THREE 2'h1
`define USSTW_WM_TWO 2'h2
`define USSTW_WM_TWO_HOLD 2'h3

// reset values and counter constants
`define USSTW_DATA_RST 8'h00
`define USSTW_CNT_RST 4'h0
`define USSTW_CNT_MAX 4'hf
`define USSTW_CNT_ONE 4'h1

// step sizes and step width used by the counter
`define USSTW_STEP_W 2
`define USSTW_STEP_NONE 2'h0
`define USSTW_STEP_ONE 2'h1

// top stage index of the edge synchronisers (second stage is the first one logic may read)
`define USSTW_SYNC_W 3

`endif

// ### logic/usstw_pkg.sv
// usstw_pkg.sv: types shared by the shift unit
// assumes: usstw_params.svh sits on the include path
`default_nettype none
`include "usstw_params.svh"

package usstw_pkg;

  // wire mode, as written through the control port
  typedef enum logic [1:0] {
    USSTW_WM_OFF_E = `USSTW_WM_OFF,
    USSTW_WM_THREE_E = `USSTW_WM_THREE,
    USSTW_WM_TWO_E = `USSTW_WM_TWO,
    USSTW_WM_TWO_HOLD_E = `USSTW_WM_TWO_HOLD
  } usstw_wm_t;

  typedef logic [`USSTW_DATA_W-1:0] usstw_data_t;
  typedef logic [`USSTW_CNT_W-1:0] usstw_cnt_t;

endpackage : usstw_pkg

`default_nettype wire

// ### logic/usstw_shift_unit.sv
// usstw_shift_unit.sv: universal serial shift unit, three-wire focus
// assumes: clk_i at 250 MHz; shift_clock_pin_i is the pin's level used
// as the link clock; software side is plain ports on clk_i
`timescale 1ns/1ps
`default_nettype none
`include "usstw_params.svh"

module usstw_shift_unit (
  // system clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // link clock: level of the shift clock pin
  input wire logic shift_clock_pin_i,
  // serial pins
  input wire logic serial_in_pin_i,
  output logic sout_pin_o,
  output logic sout_pin_oe_o,
  output logic sda_pin_o,
  output logic sda_pin_oe_o,
  output logic sck_pin_o,
  output logic sck_pin_oe_o,
  // port direction bits for the pins
  input wire logic sout_dir_i,
  input wire logic sda_dir_i,
  input wire logic sck_dir_i,
  // control write
  input wire logic ctrl_wr_i,
  input wire logic [1:0] ctrl_wire_mode_i,
  input wire logic ctrl_clock_source_select_hi_i,
  input wire logic ctrl_edge_select_bit_i,
  input wire logic ctrl_clk_bit_i,
  input wire logic ctrl_toggle_bit_i,
  // timer compare match pulse
  input wire logic timer_match_i,
  // shift data access
  input wire logic data_wr_i,
  input wire logic [7:0] data_wdata_i,
  output logic [7:0] shift_data_reg_o,
  // status access
  input wire logic stat_wr_i,
  input wire logic stat_start_clr_i,
  input wire logic stat_ovf_clr_i,
  input wire logic [3:0] stat_cnt_i,
  output logic [3:0] shift_cnt_o,
  output logic ovf_flag_o,
  output logic start_flag_o,
  // interrupt enables and requests
  input wire logic ovf_ie_i,
  input wire logic start_ie_i,
  output logic ovf_irq_o,
  output logic start_irq_o
);

  //////////////////////////////////////////////////////////////////////////
  // link domain: one toggle and one input capture per pin edge

  logic rise_tog_q;
  logic rise_bit_q;
  logic fall_tog_q;
  logic fall_bit_q;

  always_ff @(posedge shift_clock_pin_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rise_tog_q <= 1'b0;
      rise_bit_q <= 1'b0;
    end
    else
    begin
      rise_tog_q <= ~rise_tog_q;
      rise_bit_q <= serial_in_pin_i;
    end
  end

  always_ff @(negedge shift_clock_pin_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fall_tog_q <= 1'b0;
      fall_bit_q <= 1'b0;
    end
    else
    begin
      fall_tog_q <= ~fall_tog_q;
      fall_bit_q <= serial_in_pin_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // crossings into clk_i

  logic [`USSTW_SYNC_W:0] rise_tog_s_q;
  logic [`USSTW_SYNC_W:0] fall_tog_s_q;
  logic [1:0] rise_bit_s_q;
  logic [1:0] fall_bit_s_q;
  logic [2:0] sin_s_q;
  logic [1:0] scl_s_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rise_tog_s_q <= '0;
      fall_tog_s_q <= '0;
      rise_bit_s_q <= '0;
      fall_bit_s_q <= '0;
      sin_s_q <= '1;
      scl_s_q <= '1;
    end
    else
    begin
      rise_tog_s_q <= {rise_tog_s_q[`USSTW_SYNC_W-1:0], rise_tog_q};
      fall_tog_s_q <= {fall_tog_s_q[`USSTW_SYNC_W-1:0], fall_tog_q};
      rise_bit_s_q <= {rise_bit_s_q[0], rise_bit_q};
      fall_bit_s_q <= {fall_bit_s_q[0], fall_bit_q};
      sin_s_q <= {sin_s_q[1:0], serial_in_pin_i};
      scl_s_q <= {scl_s_q[0], shift_clock_pin_i};
    end
  end

  // events use stages 3/4 so the captured bit at stage 2 has settled
  logic rise_ev;
  logic fall_ev;
  assign rise_ev = rise_tog_s_q[3] ^ rise_tog_s_q[2];
  assign fall_ev = fall_tog_s_q[3] ^ fall_tog_s_q[2];

  //////////////////////////////////////////////////////////////////////////
  // control register

  usstw_pkg::usstw_wm_t wm_q;
  logic ext_q;
  logic edge_q;
  logic clkbit_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wm_q <= usstw_pkg::USSTW_WM_OFF_E;
      ext_q <= 1'b0;
      edge_q <= 1'b0;
      clkbit_q <= 1'b0;
    end
    else if (ctrl_wr_i)
    begin
      wm_q <= usstw_pkg::usstw_wm_t'(ctrl_wire_mode_i);
      ext_q <= ctrl_clock_source_select_hi_i;
      edge_q <= ctrl_edge_select_bit_i;
      clkbit_q <= ctrl_clk_bit_i;
    end
  end

  logic three_w;
  logic two_w;
  assign three_w = (wm_q == usstw_pkg::USSTW_WM_THREE_E);
  assign two_w = wm_q[1];

  //////////////////////////////////////////////////////////////////////////
  // step sources

  logic sw_step;
  logic tim_step;
  logic int_step;
  logic tog_ev;
  logic samp_ev;
  logic outp_ev;
  logic samp_bit;
  logic [1:0] cnt_step;
  logic tog_cnt;

  // software strobe only when the new setting is internal software clock
  assign sw_step = ctrl_wr_i && ctrl_clk_bit_i &&
                   !ctrl_clock_source_select_hi_i &&
                   !ctrl_edge_select_bit_i;
  assign tim_step = timer_match_i && !ext_q && edge_q;
  assign int_step = sw_step || tim_step;
  assign tog_ev = ctrl_wr_i && ctrl_toggle_bit_i;
  // a control write counts its own strobe under the settings it writes
  assign tog_cnt = ctrl_wr_i ?
                   (ctrl_clock_source_select_hi_i && ctrl_clk_bit_i) :
                   (ext_q && clkbit_q);

  // edge select picks which pin edge samples
  assign samp_ev = ext_q && (edge_q ? fall_ev : rise_ev);
  assign outp_ev = ext_q && (edge_q ? rise_ev : fall_ev);
  assign samp_bit = edge_q ? fall_bit_s_q[1] : rise_bit_s_q[1];

  // counter steps: both pin edges, toggle strobes with the clock bit, or internal strobes
  always_comb
  begin
    cnt_step = `USSTW_STEP_NONE;
    if (tog_cnt)
    begin
      cnt_step = {1'b0, tog_ev};
    end
    else if (ext_q)
    begin
      cnt_step = {1'b0, rise_ev} + {1'b0, fall_ev};
    end
    else
    begin
      cnt_step = {1'b0, int_step};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // shift register

  usstw_pkg::usstw_data_t sr_q;

  function automatic usstw_pkg::usstw_data_t shift_in(
    input usstw_pkg::usstw_data_t cur,
    input logic bit_in
  );
    shift_in = {cur[`USSTW_MSB-1:0], bit_in};
  endfunction : shift_in

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sr_q <= `USSTW_DATA_RST;
    end
    else if (data_wr_i)
    begin
      sr_q <= data_wdata_i;
    end
    else if (samp_ev)
    begin
      sr_q <= shift_in(sr_q, samp_bit);
    end
    else if (int_step)
    begin
      sr_q <= shift_in(sr_q, sin_s_q[1]);
    end
  end

  assign shift_data_reg_o = sr_q;

  //////////////////////////////////////////////////////////////////////////
  // output latch: open from the output edge to the next sampling edge, and always open with an internal clock

  logic open_q;
  logic latch_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      open_q <= 1'b1;
    end
    else if (samp_ev)
    begin
      open_q <= 1'b0;
    end
    else if (outp_ev || !ext_q)
    begin
      open_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      latch_q <= 1'b0;
    end
    else if (open_q)
    begin
      latch_q <= sr_q[`USSTW_MSB];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // counter and overflow flag

  usstw_pkg::usstw_cnt_t cnt_q;
  logic ovf_q;
  logic wrap;
  logic [`USSTW_CNT_W:0] cnt_sum;

  assign cnt_sum = {1'b0, cnt_q} + {3'h0, cnt_step};
  assign wrap = cnt_sum[`USSTW_CNT_W];

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_q <= `USSTW_CNT_RST;
    end
    else if (stat_wr_i)
    begin
      cnt_q <= stat_cnt_i;
    end
    else
    begin
      cnt_q <= cnt_sum[`USSTW_CNT_W-1:0];
    end
  end

  // a wrap in the clearing cycle still sets the flag
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ovf_q <= 1'b0;
    end
    else if (wrap)
    begin
      ovf_q <= 1'b1;
    end
    else if (stat_wr_i && stat_ovf_clr_i)
    begin
      ovf_q <= 1'b0;
    end
  end

  assign shift_cnt_o = cnt_q;
  assign ovf_flag_o = ovf_q;
  assign ovf_irq_o = ovf_q && ovf_ie_i;

  //////////////////////////////////////////////////////////////////////////
  // two-wire start detector and clock hold

  logic start_q;
  logic start_det;
  logic hold;

  assign start_det = two_w && sin_s_q[2] && !sin_s_q[1] && scl_s_q[1];

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      start_q <= 1'b0;
    end
    else if (start_det)
    begin
      start_q <= 1'b1;
    end
    else if (stat_wr_i && stat_start_clr_i)
    begin
      start_q <= 1'b0;
    end
  end

  // hold once the master has pulled the clock low after a start
  assign hold = (start_q && !scl_s_q[1] && two_w) ||
                (ovf_q && wm_q == usstw_pkg::USSTW_WM_TWO_HOLD_E);

  assign start_flag_o = start_q;
  assign start_irq_o = start_q && start_ie_i;

  //////////////////////////////////////////////////////////////////////////
  // pin drivers

  logic sck_q;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sck_q <= 1'b0;
    end
    else if (tog_ev)
    begin
      sck_q <= ~sck_q;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sout_pin_o <= 1'b0;
      sout_pin_oe_o <= 1'b0;
      sda_pin_o <= 1'b0;
      sda_pin_oe_o <= 1'b0;
      sck_pin_o <= 1'b0;
      sck_pin_oe_o <= 1'b0;
    end
    else
    begin
      // three-wire: push-pull data out, no slave select
      sout_pin_o <= latch_q;
      sout_pin_oe_o <= three_w && sout_dir_i;
      // two-wire: open drain, pulls low for a zero
      sda_pin_o <= 1'b0;
      sda_pin_oe_o <= two_w && sda_dir_i && !latch_q;
      sck_pin_o <= two_w ? 1'b0 : sck_q;
      sck_pin_oe_o <= two_w ? (hold || (sck_dir_i && !sck_q)) :
                      (three_w && sck_dir_i);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  shift_on_sample_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    samp_ev && !data_wr_i |=>
      sr_q == {$past(sr_q[`USSTW_MSB-1:0]), $past(samp_bit)})
    else $error("shift register missed a sampling edge");

  count_both_edges_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    ext_q && !tog_cnt && !stat_wr_i && (rise_ev ^ fall_ev) |=>
      cnt_q == $past(cnt_q) + `USSTW_CNT_ONE)
    else $error("pin edge not counted");

  ovf_on_wrap_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    cnt_q == `USSTW_CNT_MAX && cnt_step == `USSTW_STEP_ONE && !stat_wr_i
      |=> ovf_q && cnt_q == `USSTW_CNT_RST)
    else $error("counter wrap did not set overflow");

  status_clear_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    stat_wr_i && stat_ovf_clr_i && stat_cnt_i == `USSTW_CNT_RST && !wrap
      |=> !ovf_q && cnt_q == `USSTW_CNT_RST)
    else $error("status write did not clear flag and count");

  sck_toggle_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    tog_ev |=> sck_q != $past(sck_q) ##1 sck_pin_o == (two_w ? 1'b0 :
      $past(sck_q)))
    else $error("toggle strobe did not flip the clock pin");

  latch_closed_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    samp_ev && !outp_ev ##1 !outp_ev [*2] |=> latch_q == $past(latch_q, 2))
    else $error("output changed on the sampling edge");

  sout_route_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    three_w |=> sout_pin_o == $past(latch_q) && !sda_pin_oe_o)
    else $error("data out not routed for three-wire");

  toggle_count_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    tog_ev && ctrl_clock_source_select_hi_i && ctrl_clk_bit_i &&
      !stat_wr_i |=>
      cnt_q == $past(cnt_q) + `USSTW_CNT_ONE)
    else $error("toggle strobe not counted");

  sw_strobe_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    sw_step && !ext_q && !data_wr_i && !stat_wr_i |=>
      cnt_q == $past(cnt_q) + `USSTW_CNT_ONE &&
      sr_q == {$past(sr_q[`USSTW_MSB-1:0]), $past(sin_s_q[1])})
    else $error("software strobe did not step");

  start_hold_a: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    hold |=> sck_pin_oe_o && !sck_pin_o)
    else $error("clock not held low");

endmodule : usstw_shift_unit

`default_nettype wire

// ### testbench/testbench.sv
// testbench.sv: self-checking bench for the shift unit
// assumes: unit as slave against the peer master model
`timescale 1ns/1ps
`default_nettype none

module testbench;

  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sout_dir_i = 1'b0;
  logic sda_dir_i = 1'b0;
  logic sck_dir_i = 1'b0;
  logic ctrl_wr_i = 1'b0;
  logic [1:0] ctrl_wire_mode_i = 2'h0;
  logic ctrl_hi_i = 1'b0;
  logic ctrl_edge_i = 1'b0;
  logic ctrl_clk_i = 1'b0;
  logic ctrl_tog_i = 1'b0;
  logic timer_match_i = 1'b0;
  logic data_wr_i = 1'b0;
  logic [7:0] data_wdata_i = 8'h00;
  logic stat_wr_i = 1'b0;
  logic stat_ovf_clr_i = 1'b0;
  logic [3:0] stat_cnt_i = 4'h0;
  logic ovf_ie_i = 1'b0;
  logic stat_start_clr_i = 1'b0;
  logic start_ie_i = 1'b0;
  logic sda_pin_oe_o, start_flag_o, start_irq_o;
  wire logic peer_sck, peer_mosi, sck_wire, sout_wire;
  logic sout_pin_o, sout_pin_oe_o, sck_pin_o, sck_pin_oe_o;
  logic ovf_flag_o, ovf_irq_o;
  logic [7:0] shift_data_reg_o;
  logic [3:0] shift_cnt_o;
  logic [7:0] rx;
  int errors = 0;
  int cmp_count = 0;

  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  assign sck_wire = sck_pin_oe_o ? sck_pin_o : peer_sck;
  assign sout_wire = sout_pin_oe_o ? sout_pin_o : ~sout_pin_o;

  usstw_shift_unit uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .shift_clock_pin_i(sck_wire),
    .serial_in_pin_i(peer_mosi), .sout_pin_o(sout_pin_o),
    .sout_pin_oe_o(sout_pin_oe_o), .sda_pin_o(),
    .sda_pin_oe_o(sda_pin_oe_o),
    .sck_pin_o(sck_pin_o), .sck_pin_oe_o(sck_pin_oe_o),
    .sout_dir_i(sout_dir_i), .sda_dir_i(sda_dir_i), .sck_dir_i(sck_dir_i),
    .ctrl_wr_i(ctrl_wr_i), .ctrl_wire_mode_i(ctrl_wire_mode_i),
    .ctrl_clock_source_select_hi_i(ctrl_hi_i),
    .ctrl_edge_select_bit_i(ctrl_edge_i), .ctrl_clk_bit_i(ctrl_clk_i),
    .ctrl_toggle_bit_i(ctrl_tog_i), .timer_match_i(timer_match_i),
    .data_wr_i(data_wr_i), .data_wdata_i(data_wdata_i),
    .shift_data_reg_o(shift_data_reg_o), .stat_wr_i(stat_wr_i),
    .stat_start_clr_i(stat_start_clr_i), .stat_ovf_clr_i(stat_ovf_clr_i),
    .stat_cnt_i(stat_cnt_i), .shift_cnt_o(shift_cnt_o),
    .ovf_flag_o(ovf_flag_o), .start_flag_o(start_flag_o),
    .ovf_ie_i(ovf_ie_i), .start_ie_i(start_ie_i), .ovf_irq_o(ovf_irq_o),
    .start_irq_o(start_irq_o)
  );

  usstw_peer_master peer (
    .sck_o(peer_sck), .mosi_o(peer_mosi), .miso_i(sout_wire)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : settle

  task automatic ctrl(input logic [1:0] wm, input logic hi, edge_b,
                      input logic clk_b, tog);
    @(posedge clk_i);
    ctrl_wire_mode_i <= wm;
    ctrl_hi_i <= hi;
    ctrl_edge_i <= edge_b;
    ctrl_clk_i <= clk_b;
    ctrl_tog_i <= tog;
    ctrl_wr_i <= 1'b1;
    @(posedge clk_i);
    ctrl_wr_i <= 1'b0;
  endtask : ctrl

  task automatic data_wr(input logic [7:0] d);
    @(posedge clk_i);
    data_wdata_i <= d;
    data_wr_i <= 1'b1;
    @(posedge clk_i);
    data_wr_i <= 1'b0;
  endtask : data_wr

  task automatic stat_wr(input logic clr, input logic [3:0] cnt);
    @(posedge clk_i);
    stat_ovf_clr_i <= clr;
    stat_start_clr_i <= clr;
    stat_cnt_i <= cnt;
    stat_wr_i <= 1'b1;
    @(posedge clk_i);
    stat_wr_i <= 1'b0;
  endtask : stat_wr

  task automatic complete_run;
    if (errors == 0 && cmp_count > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    #20000;
    errors++;
    complete_run();
  end

  initial
  begin
    peer.set_di(1'b1);
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    settle(1);
    chk("data after reset", 8'h00, shift_data_reg_o);
    chk("count after reset", 8'h00, {4'h0, shift_cnt_o});
    chk("flag after reset", 8'h00, {7'h00, ovf_flag_o});
    // software strobe steps register and counter together
    data_wr(8'ha5);
    ctrl(2'h0, 1'b0, 1'b0, 1'b1, 1'b0);
    settle(2);
    chk("strobe shift", 8'h4b, shift_data_reg_o);
    chk("strobe count", 8'h01, {4'h0, shift_cnt_o});
    // timer compare match as clock source
    ctrl(2'h0, 1'b0, 1'b1, 1'b0, 1'b0);
    @(posedge clk_i);
    timer_match_i <= 1'b1;
    @(posedge clk_i);
    timer_match_i <= 1'b0;
    settle(2);
    chk("timer count", 8'h02, {4'h0, shift_cnt_o});
    chk("timer shift", 8'h97, shift_data_reg_o);
    // wrap from the top count, then clear flag and count
    stat_wr(1'b0, 4'hf);
    ovf_ie_i <= 1'b1;
    ctrl(2'h0, 1'b0, 1'b0, 1'b1, 1'b0);
    settle(2);
    chk("wrap count", 8'h00, {4'h0, shift_cnt_o});
    chk("wrap flag", 8'h01, {7'h00, ovf_flag_o});
    chk("wrap request", 8'h01, {7'h00, ovf_irq_o});
    stat_wr(1'b1, 4'h0);
    settle(1);
    chk("cleared flag", 8'h00, {7'h00, ovf_flag_o});
    chk("cleared request", 8'h00, {7'h00, ovf_irq_o});
    // three-wire slave byte against the peer master
    ctrl(2'h1, 1'b1, 1'b0, 1'b0, 1'b0);
    sout_dir_i <= 1'b1;
    data_wr(8'h3c);
    stat_wr(1'b1, 4'h0);
    settle(4);
    chk("msb on data out", 8'h00, {7'h00, sout_pin_o});
    chk("data out driven", 8'h01, {7'h00, sout_pin_oe_o});
    #3;
    peer.xfer(8'hc5, rx);
    settle(10);
    chk("unit received", 8'hc5, shift_data_reg_o);
    chk("peer received", 8'h3c, rx);
    chk("byte count", 8'h00, {4'h0, shift_cnt_o});
    chk("byte flag", 8'h01, {7'h00, ovf_flag_o});
    // master clocking by toggle strobes, counter follows strobes
    peer.set_di(1'b1);
    stat_wr(1'b1, 4'h0);
    sck_dir_i <= 1'b1;
    ctrl(2'h1, 1'b1, 1'b0, 1'b1, 1'b1);
    settle(3);
    chk("clock pin high", 8'h01, {7'h00, sck_pin_o});
    chk("toggle count one", 8'h01, {4'h0, shift_cnt_o});
    ctrl(2'h1, 1'b1, 1'b0, 1'b1, 1'b1);
    settle(3);
    chk("clock pin low", 8'h00, {7'h00, sck_pin_o});
    chk("toggle count two", 8'h02, {4'h0, shift_cnt_o});
    chk("clock pin driven", 8'h01, {7'h00, sck_pin_oe_o});
    repeat (14) ctrl(2'h1, 1'b1, 1'b0, 1'b1, 1'b1);
    settle(6);
    chk("toggle wrap count", 8'h00, {4'h0, shift_cnt_o});
    chk("toggle wrap flag", 8'h01, {7'h00, ovf_flag_o});
    chk("master shifted", 8'hff, shift_data_reg_o);
    // two-wire: a start sets the flag, then the clock is held low
    stat_wr(1'b1, 4'h0);
    sck_dir_i <= 1'b0;
    sda_dir_i <= 1'b1;
    start_ie_i <= 1'b1;
    ctrl(2'h2, 1'b1, 1'b0, 1'b0, 1'b0);
    data_wr(8'h00);
    settle(4);
    chk("data pin pulled", 8'h01, {7'h00, sda_pin_oe_o});
    chk("data out off", 8'h00, {7'h00, sout_pin_oe_o});
    peer.start_cond();
    settle(4);
    chk("start flag", 8'h01, {7'h00, start_flag_o});
    chk("start request", 8'h01, {7'h00, start_irq_o});
    chk("start hold", 8'h01, {7'h00, sck_pin_oe_o});
    stat_wr(1'b1, 4'h0);
    settle(2);
    chk("start cleared", 8'h00, {7'h00, start_flag_o});
    chk("start released", 8'h00, {7'h00, sck_pin_oe_o});
    // wire mode 3: an overflow holds the clock low
    ctrl(2'h3, 1'b0, 1'b0, 1'b0, 1'b0);
    stat_wr(1'b0, 4'hf);
    ctrl(2'h3, 1'b0, 1'b0, 1'b1, 1'b0);
    settle(3);
    chk("overflow hold", 8'h01, {7'h00, sck_pin_oe_o});
    chk("hold clock low", 8'h00, {7'h00, sck_pin_o});
    stat_wr(1'b1, 4'h0);
    settle(2);
    chk("overflow released", 8'h00, {7'h00, sck_pin_oe_o});
    complete_run();
  end

endmodule : testbench

`default_nettype wire

// ### testbench/usstw_peer_master.sv
// usstw_peer_master.sv: behavioural three-wire master facing the unit
// assumes: unit runs as slave, mode 0; link clock made here, 30 ns
`timescale 1ns/1ps
`default_nettype none

module usstw_peer_master (
  // link pins
  output logic sck_o,
  output logic mosi_o,
  input wire logic miso_i
);

  initial
  begin
    sck_o = 1'b0;
    mosi_o = 1'b0;
  end

  // level on the data line outside frames
  task automatic set_di(input logic v);
    mosi_o = v;
  endtask : set_di

  // two-wire start: data falls while the clock is high
  task automatic start_cond;
    mosi_o = 1'b1;
    #15 sck_o = 1'b1;
    #15 mosi_o = 1'b0;
    #15 sck_o = 1'b0;
    #15;
  endtask : start_cond

  // one byte, msb first; clock stands still outside the frame
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    rx = 8'h00;
    mosi_o = tx[7];
    #15; // setup a whole period before first sample
    for (int i = 0; i < 8; i++)
    begin
      #15 sck_o = 1'b1; // sample edge is the rise
      #15;
      rx = {rx[6:0], miso_i}; // ring exchange
      sck_o = 1'b0;
      if (i < 7)
      begin
        mosi_o = tx[6 - i];
      end
    end
    // released line shows the inverse of its last value
    #15 mosi_o = ~mosi_o;
  endtask : xfer

endmodule : usstw_peer_master

`default_nettype wire
